// *** rtl/bem_consts.svh ***
// What this block does
// [RULE1] Low mask accepts written integers 0 to 255; host keeps values in range.
// [RULE2] High mask accepts 0 to 255, all eight bits written together.
// [RULE3] Written values may carry a fraction; round to integer before storing.
// [RULE4] Both masks clear to zero at power-up.
// [RULE5] Low mask query answers stored value as plain unsigned decimal.
// [RULE6] Low mask bits 0..7 enable bin one..eight, weights 1..128.
// [RULE7] High mask: bits 0-5 bins nine-fourteen, bit 6 out-of-bins, bit 7 failed judgment.
// [RULE8] Header on: answer prefixed with command name; off: number only.
// [RULE9] Variant without bin sorting never raises any masked bin event.
// [RULE10] Each mask bit gates the same-position event into the summary.
`ifndef BEM_CONSTS_SVH
`define BEM_CONSTS_SVH

// ==========================================================
// Reset values and limits
`define BEM_MASK_RST 8'h00
`define BEM_MASK_MAX 8'hFF
`define BEM_ROUND_DIGIT 4'h5

// ==========================================================
// High mask field positions
`define BEM_HIGH_BIN_MSB 5
`define BEM_HIGH_OUT_BIT 6
`define BEM_HIGH_FAIL_BIT 7

// ==========================================================
// Characters of the command text
`define BEM_CH_COLON 8'h3A
`define BEM_CH_E 8'h45
`define BEM_CH_S 8'h53
`define BEM_CH_TWO 8'h32
`define BEM_CH_THREE 8'h33
`define BEM_CH_QUERY 8'h3F
`define BEM_CH_SPACE 8'h20
`define BEM_CH_DOT 8'h2E
`define BEM_CH_ZERO 8'h30
`define BEM_CH_NINE 8'h39
`define BEM_CH_LF 8'h0A
`define BEM_CH_LOW_A 8'h61
`define BEM_CH_LOW_Z 8'h7A
`define BEM_CASE_DIFF 8'h20

// ==========================================================
// Response sequence positions
`define BEM_TX_SEL 4'h4
`define BEM_TX_HUND 4'h6
`define BEM_TX_TENS 4'h7
`define BEM_TX_ONES 4'h8
`define BEM_TX_LF 4'h9

`endif

// *** rtl/bem_enable_masks.sv ***
`include "bem_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module bem_enable_masks import bem_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command text in
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Response text out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Mode
  input wire logic header_enable,
  input wire logic bin_present,
  // Events
  input wire bem_events_t events_in,
  output bem_gated_t gated_out
);

  // ==========================================================
  // Character intake
  bem_pstate_t pstate_reg;
  logic [7:0] bin_event_enable_low;
  logic [7:0] bin_event_enable_high;
  logic sel_high_reg;
  logic [7:0] acc_reg;
  logic got_digit_reg;
  logic frac_seen_reg;
  logic round_up_reg;
  logic [3:0] tx_idx_reg;
  logic [7:0] tx_data_reg;
  logic [7:0] ch;
  logic rx_fire;
  logic tx_fire;
  logic is_digit;
  logic [3:0] digit;
  logic [11:0] acc_next;
  logic commit;
  logic [7:0] rounded;
  logic query_done;
  logic [7:0] sel_val;
  logic [3:0] d_hund;
  logic [3:0] d_tens;
  logic [3:0] d_ones;
  logic [3:0] first_idx;
  logic tx_last;

  // Lower case letters are folded so commands are case-blind
  always_comb begin
    if (rx_data >= `BEM_CH_LOW_A && rx_data <= `BEM_CH_LOW_Z) begin
      ch = rx_data - `BEM_CASE_DIFF;
    end else begin
      ch = rx_data;
    end
  end

  // Intake stalls while a response is going out
  assign rx_ready = (pstate_reg != P_TX);
  assign rx_fire = rx_valid && rx_ready;
  assign tx_valid = (pstate_reg == P_TX);
  assign tx_fire = tx_valid && tx_ready;
  assign tx_data = tx_data_reg;
  assign tx_last = (tx_idx_reg == `BEM_TX_LF);
  assign is_digit = (ch >= `BEM_CH_ZERO) && (ch <= `BEM_CH_NINE);
  assign digit = 4'(ch - `BEM_CH_ZERO);
  assign acc_next = 12'(acc_reg) * 12'd10 + 12'(digit);
  assign commit = rx_fire && (ch == `BEM_CH_LF) && got_digit_reg &&
                  ((pstate_reg == P_NUM) || (pstate_reg == P_FRAC));
  assign query_done = rx_fire && (ch == `BEM_CH_LF) && (pstate_reg == P_QEND);

  function automatic bem_pstate_t bad_char(input logic [7:0] c);
    bad_char = (c == `BEM_CH_LF) ? P_IDLE : P_SKIP;
  endfunction

  // ==========================================================
  // Command parser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pstate_reg <= P_IDLE;
      sel_high_reg <= 1'b0;
    end else if (tx_fire && tx_last) begin
      pstate_reg <= P_IDLE;
    end else if (rx_fire) begin
      case (pstate_reg)
        P_IDLE: begin
          if (ch == `BEM_CH_COLON) pstate_reg <= P_E;
        end
        P_E: begin
          pstate_reg <= (ch == `BEM_CH_E) ? P_S : bad_char(ch);
        end
        P_S: begin
          pstate_reg <= (ch == `BEM_CH_S) ? P_E2 : bad_char(ch);
        end
        P_E2: begin
          pstate_reg <= (ch == `BEM_CH_E) ? P_SEL : bad_char(ch);
        end
        P_SEL: begin
          if (ch == `BEM_CH_TWO || ch == `BEM_CH_THREE) begin
            sel_high_reg <= (ch == `BEM_CH_THREE);
            pstate_reg <= P_OP;
          end else begin
            pstate_reg <= bad_char(ch);
          end
        end
        P_OP: begin
          if (ch == `BEM_CH_QUERY) pstate_reg <= P_QEND;
          else if (ch == `BEM_CH_SPACE) pstate_reg <= P_NUM;
          else pstate_reg <= bad_char(ch);
        end
        P_NUM: begin
          if (ch == `BEM_CH_DOT) pstate_reg <= P_FRAC;
          else if (ch == `BEM_CH_LF) pstate_reg <= P_IDLE;
          else if (!is_digit && !(ch == `BEM_CH_SPACE && !got_digit_reg)) pstate_reg <= P_SKIP;
        end
        P_FRAC: begin
          if (ch == `BEM_CH_LF) pstate_reg <= P_IDLE;
          else if (!is_digit) pstate_reg <= P_SKIP;
        end
        P_QEND: begin
          if (ch == `BEM_CH_LF) pstate_reg <= P_TX;
          else if (ch != `BEM_CH_SPACE) pstate_reg <= P_SKIP;
        end
        P_SKIP: begin
          if (ch == `BEM_CH_LF) pstate_reg <= P_IDLE;
        end
        default: begin
          pstate_reg <= P_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Numeric value gathering
  // [RULE3] fraction rounding
  always_ff @(posedge ref_clk) begin
    if (rst || (rx_fire && pstate_reg == P_OP)) begin
      acc_reg <= `BEM_MASK_RST;
      got_digit_reg <= 1'b0;
      frac_seen_reg <= 1'b0;
      round_up_reg <= 1'b0;
    end else if (rx_fire && is_digit && pstate_reg == P_NUM) begin
      // Saturate rather than wrap so out-of-range input cannot alias
      acc_reg <= (acc_next > 12'(`BEM_MASK_MAX)) ? `BEM_MASK_MAX : acc_next[7:0];
      got_digit_reg <= 1'b1;
    end else if (rx_fire && is_digit && pstate_reg == P_FRAC && !frac_seen_reg) begin
      round_up_reg <= (digit >= `BEM_ROUND_DIGIT);
      frac_seen_reg <= 1'b1;
      got_digit_reg <= 1'b1;
    end
  end

  assign rounded = (round_up_reg && acc_reg != `BEM_MASK_MAX) ? acc_reg + 8'h01 : acc_reg;

  // ==========================================================
  // Mask registers
  // [RULE4] power-up clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bin_event_enable_low <= `BEM_MASK_RST;
      bin_event_enable_high <= `BEM_MASK_RST;
    end else if (commit) begin
      // [RULE1] low mask write
      if (!sel_high_reg) bin_event_enable_low <= rounded;
      // [RULE2] high mask write
      if (sel_high_reg) bin_event_enable_high <= rounded;
    end
  end

  // ==========================================================
  // Response text
  // [RULE5] plain decimal answer
  assign sel_val = sel_high_reg ? bin_event_enable_high : bin_event_enable_low;
  assign d_hund = 4'(sel_val / 8'd100);
  assign d_tens = 4'((sel_val / 8'd10) % 8'd10);
  assign d_ones = 4'(sel_val % 8'd10);
  // Leading zeros are suppressed so zero answers as a single digit
  assign first_idx = (d_hund != 4'h0) ? `BEM_TX_HUND :
                     (d_tens != 4'h0) ? `BEM_TX_TENS : `BEM_TX_ONES;

  function automatic logic [7:0] tx_char(input logic [3:0] idx, input logic [3:0] h,
                                         input logic [3:0] t, input logic [3:0] o,
                                         input logic hi);
    case (idx)
      4'h0: tx_char = `BEM_CH_COLON;
      4'h1: tx_char = `BEM_CH_E;
      4'h2: tx_char = `BEM_CH_S;
      4'h3: tx_char = `BEM_CH_E;
      `BEM_TX_SEL: tx_char = hi ? `BEM_CH_THREE : `BEM_CH_TWO;
      4'h5: tx_char = `BEM_CH_SPACE;
      `BEM_TX_HUND: tx_char = `BEM_CH_ZERO + 8'(h);
      `BEM_TX_TENS: tx_char = `BEM_CH_ZERO + 8'(t);
      `BEM_TX_ONES: tx_char = `BEM_CH_ZERO + 8'(o);
      default: tx_char = `BEM_CH_LF;
    endcase
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_idx_reg <= 4'h0;
      tx_data_reg <= `BEM_CH_LF;
    end else if (query_done) begin
      // [RULE8] header echo choice
      if (header_enable) begin
        tx_idx_reg <= 4'h0;
        tx_data_reg <= `BEM_CH_COLON;
      end else begin
        tx_idx_reg <= first_idx;
        tx_data_reg <= tx_char(first_idx, d_hund, d_tens, d_ones, sel_high_reg);
      end
    end else if (tx_fire && !tx_last) begin
      if (tx_idx_reg == 4'h5) begin
        tx_idx_reg <= first_idx;
        tx_data_reg <= tx_char(first_idx, d_hund, d_tens, d_ones, sel_high_reg);
      end else begin
        tx_idx_reg <= tx_idx_reg + 4'h1;
        tx_data_reg <= tx_char(tx_idx_reg + 4'h1, d_hund, d_tens, d_ones, sel_high_reg);
      end
    end
  end

  // ==========================================================
  // Event gating
  // [RULE10] per-bit enable gating
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gated_out <= '0;
    end else if (!bin_present) begin
      // [RULE9] no bin events without sorting
      gated_out <= '0;
    end else begin
      // [RULE6] bins one to eight
      gated_out.enabled_low <= events_in.bin_events[7:0] & bin_event_enable_low;
      // [RULE7] bins nine up, out, failed
      gated_out.enabled_high <= {events_in.failed_judgment_event, events_in.out_of_bins_event,
                                 events_in.bin_events[13:8]} & bin_event_enable_high;
      gated_out.summary_low <= |(events_in.bin_events[7:0] & bin_event_enable_low);
      gated_out.summary_high <= |({events_in.failed_judgment_event, events_in.out_of_bins_event,
                                   events_in.bin_events[13:8]} & bin_event_enable_high);
    end
  end

  // ==========================================================
  // Checks
  a_masks_reset: assert property (@(posedge ref_clk) rst |=> // [RULE4]
    bin_event_enable_low == 8'h00 && bin_event_enable_high == 8'h00)
    else $error("masks not zero after reset");
  a_low_write: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    commit && !sel_high_reg |=> bin_event_enable_low == $past(rounded) && $stable(bin_event_enable_high))
    else $error("low mask write wrong");
  a_high_round: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    commit && sel_high_reg && round_up_reg && acc_reg != 8'hFF |=> bin_event_enable_high == $past(acc_reg) + 8'h01)
    else $error("high mask rounding wrong");
  a_high_write: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    commit && sel_high_reg |=> bin_event_enable_high == $past(rounded) && $stable(bin_event_enable_low))
    else $error("high mask write wrong");
  a_low_gate: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    bin_present |=> gated_out.enabled_low == ($past(events_in.bin_events[7:0]) & $past(bin_event_enable_low)))
    else $error("low gating wrong");
  a_fail_gate: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    bin_present && events_in.failed_judgment_event && bin_event_enable_high[7] |=> gated_out.enabled_high[7]
    && gated_out.summary_high)
    else $error("failed judgment not passed");
  a_no_bins: assert property (@(posedge ref_clk) disable iff (rst) // [RULE9]
    !bin_present |=> gated_out == '0)
    else $error("event raised without sorting");
  a_summary_off: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    bin_event_enable_low == 8'h00 |=> !gated_out.summary_low)
    else $error("summary raised while masked");
  a_header_first: assert property (@(posedge ref_clk) disable iff (rst) // [RULE8]
    query_done |=> (tx_data == 8'h3A) == $past(header_enable) && tx_valid)
    else $error("header echo wrong");
  a_answer_ends: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    tx_fire && tx_last |=> pstate_reg == P_IDLE && !tx_valid)
    else $error("response did not end");

endmodule

`default_nettype wire

// *** rtl/bem_pkg.sv ***
package bem_pkg;

  typedef struct packed {
    logic failed_judgment_event;
    logic out_of_bins_event;
    logic [13:0] bin_events;
  } bem_events_t;

  typedef struct packed {
    logic [7:0] enabled_low;
    logic [7:0] enabled_high;
    logic summary_low;
    logic summary_high;
  } bem_gated_t;

  typedef enum logic [3:0] {
    P_IDLE = 4'b0000,
    P_E = 4'b0001,
    P_S = 4'b0011,
    P_E2 = 4'b0010,
    P_SEL = 4'b0110,
    P_OP = 4'b0111,
    P_NUM = 4'b0101,
    P_FRAC = 4'b0100,
    P_QEND = 4'b1100,
    P_TX = 4'b1101,
    P_SKIP = 4'b1111
  } bem_pstate_t;

endpackage

// *** verif/bem_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module bem_host_model (
  // Clock
  input wire logic ref_clk,
  // Command text
  output var logic [7:0] rx_data,
  output var logic rx_valid,
  input wire logic rx_ready,
  // Response text
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output var logic tx_ready,
  // Sink pacing
  input wire logic slow
);
  initial begin
    rx_data = 8'h5A;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end

  // ==========================================
  // Sink pacing
  // Slow mode stalls every other cycle
  always @(posedge ref_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // ==========================================
  // Command sender
  // Leading edge keeps two drives apart
  task automatic send_line(input string s);
    int n;
    @(posedge ref_clk);
    for (int i = 0; i < s.len(); i++) begin
      rx_data <= s[i];
      rx_valid <= 1'b1;
      n = 0;
      // Ready is judged settled, ahead of the edge that takes the character
      @(negedge ref_clk);
      while (rx_ready !== 1'b1 && n < 200) begin
        @(negedge ref_clk);
        n++;
      end
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    // Released line shows no stale character
    rx_data <= ~s[s.len() - 1];
  endtask

  // ==========================================
  // Response collector, line end shown as ;
  task automatic get_resp(output string r);
    int n;
    r = "";
    n = 0;
    // Looked at between edges so the taken character is the one recorded
    while (n < 400) begin
      @(negedge ref_clk);
      n++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r = {r, tx_data == 8'h0A ? ";" : $sformatf("%c", tx_data)};
        if (tx_data == 8'h0A) n = 400;
      end
    end
  endtask
endmodule

`default_nettype wire

// *** verif/tb_bem_enable_masks.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_bem_enable_masks;
  import bem_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic header_enable = 1'b0;
  logic bin_present = 1'b1;
  logic slow = 1'b0;
  bem_events_t events_in = '0;
  bem_gated_t gated_out;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32'hb341_2880;
  logic [7:0] lo_m = 8'h00;
  logic [7:0] hi_m = 8'h00;
  string got;

  bem_enable_masks bem_enable_masks_inst (.ref_clk(ref_clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .header_enable(header_enable), .bin_present(bin_present), .events_in(events_in), .gated_out(gated_out));
  bem_host_model bem_host_model_inst (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Checking and verdict
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp_text(string what, string exp, string seen);
    n_compared++;
    if (exp != seen) begin
      mismatches++;
      $display("wrong value %s expected %s seen %s", what, exp, seen);
    end
  endtask

  task automatic cmp_gate(bem_gated_t exp);
    n_compared++;
    if (gated_out !== exp) begin
      mismatches++;
      $display("wrong value gated_out expected %h seen %h", exp, gated_out);
    end
  endtask

  function automatic string resp(logic hi, logic [7:0] v, logic hdr);
    return hdr ? $sformatf(":ESE%0d %0d;", hi ? 3 : 2, v) : $sformatf("%0d;", v);
  endfunction

  function automatic bem_gated_t gate(bem_events_t e, logic bp);
    bem_gated_t g;
    g.enabled_low = e.bin_events[7:0] & lo_m;
    g.enabled_high = {e.failed_judgment_event, e.out_of_bins_event, e.bin_events[13:8]} & hi_m;
    g.summary_low = |g.enabled_low;
    g.summary_high = |g.enabled_high;
    return bp ? g : '0;
  endfunction

  // ==========================================
  // Operations
  task automatic query(logic hi);
    @(posedge ref_clk);
    header_enable <= 1'($random(seed));
    bem_host_model_inst.send_line($sformatf(":ESE%0d?\n", hi ? 3 : 2));
    bem_host_model_inst.get_resp(got);
    cmp_text("answer", resp(hi, hi ? hi_m : lo_m, header_enable), got);
  endtask

  // Letter case follows the parity of n_compared, so it alternates between bit-walk steps to exercise folding
  task automatic wr(logic hi, string num, logic [7:0] v);
    bem_host_model_inst.send_line($sformatf(":%s%0d %s\n", n_compared[0] ? "ese" : "ESE", hi ? 3 : 2, num));
    if (hi) hi_m = v;
    else lo_m = v;
  endtask

  task automatic ev(bem_events_t e, logic bp);
    @(posedge ref_clk);
    events_in <= e;
    bin_present <= bp;
    @(posedge ref_clk);
    // Gated result is registered at the edge above; read it settled
    @(negedge ref_clk);
    cmp_gate(gate(e, bp));
  endtask

  initial begin
    #300us;
    mismatches++;
    close_out();
  end

  initial begin
    int ip;
    string num;
    logic hi;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    query(1'b0);
    query(1'b1);
    for (int b = 0; b < 8; b++) begin
      wr(1'b0, $sformatf("%0d", 1 << b), 8'(1 << b));
      wr(1'b1, $sformatf("%0d", 1 << b), 8'(1 << b));
      ev(16'hFFFF, 1'b1);
    end
    wr(1'b1, "255.7", 8'hFF);
    wr(1'b0, "0.5", 8'h01);
    // A line without a number and a misspelt command line are dropped
    bem_host_model_inst.send_line($sformatf(":ESE%0d \n", 2));
    bem_host_model_inst.send_line(":ESX2 9\n");
    query(1'b0);
    query(1'b1);
    for (int k = 0; k < 40; k++) begin
      hi = 1'($random(seed));
      ip = {$random(seed)} % 256;
      num = k[0] ? $sformatf("%0d.%0d", ip, {$random(seed)} % 10) : $sformatf("%0d", ip);
      slow <= 1'($random(seed));
      if (k[0] && num[num.len() - 1] >= "5") ip = ip == 255 ? 255 : ip + 1;
      wr(hi, num, 8'(ip));
      query(hi);
      ev(16'($random(seed)), k % 5 != 0);
    end
    close_out();
  end
endmodule

`default_nettype wire
